/* design/ssi_pkg.sv */
// Summary of operation
// - halt input cuts output, applies fault reaction
// - shorted over-travel input permits that direction
// - prohibition, selections 0 and 3: decelerate, then servo lock, no error
// - selection 1 disables prohibition: no decel, lock or error
// - selection 2 raises prohibition error 38.0
// - prohibition active for any selection except 1
// - eight selectors give function and polarity per input
// - slowdown input at search speed drops to zero-search
// - slowdown sampled but ignored in speed/force modes
// - latch trigger captures feedback pulse counter
// - latch triggers on rising edge after 2 ms low
// - latches only non-inverted, only inputs five to seven
// - monitor inputs only reported as status
// - force clamp inputs limit force to set limits
// - protection starts 1.5 s after init, extendable
// - ready needs init, main power, no error, sync
// - brake release on servo or fieldbus request
// - pole-complete output only with detection method 2
// - pole-complete stays low if estimation fails
package ssi_pkg;

	// ----------------------------------------
	// input function codes
	// ----------------------------------------
	localparam logic [3:0] FN_NONE      = 4'h0;
	localparam logic [3:0] FN_HALT      = 4'h1;
	localparam logic [3:0] FN_FWD_BLOCK = 4'h2;
	localparam logic [3:0] FN_REV_BLOCK = 4'h3;
	localparam logic [3:0] FN_SLOWDOWN  = 4'h4;
	localparam logic [3:0] FN_LATCH1    = 4'h5;
	localparam logic [3:0] FN_LATCH2    = 4'h6;
	localparam logic [3:0] FN_LATCH3    = 4'h7;
	localparam logic [3:0] FN_MONITOR0  = 4'h8;
	localparam logic [3:0] FN_MONITOR1  = 4'h9;
	localparam logic [3:0] FN_MONITOR2  = 4'ha;
	localparam logic [3:0] FN_FWD_CLAMP = 4'hb;
	localparam logic [3:0] FN_REV_CLAMP = 4'hc;

	// ----------------------------------------
	// selector field layout: [4] invert, [3:0] function
	// ----------------------------------------
	localparam int SEL_W       = 5;
	localparam int SEL_INV_BIT = 4;
	localparam int NUM_IN      = 8;
	localparam int LATCH_FIRST = 4;
	localparam int LATCH_LAST  = 6;

	// ----------------------------------------
	// setting encodings
	// ----------------------------------------
	localparam logic [1:0] PROHIB_SEL_ERR  = 2'h2;
	localparam logic [1:0] PROHIB_SEL_STOP = 2'h1;
	localparam logic [1:0] POLE_METHOD_EST = 2'h2;
	localparam logic [7:0] ERR_PROHIBIT    = 8'h26; // error 38.0 main code
	localparam logic [2:0] MODE_POS        = 3'h0;
	localparam logic [2:0] MODE_SPEED      = 3'h1;
	localparam logic [2:0] MODE_FORCE      = 3'h2;
	localparam logic [2:0] MODE_HOMING     = 3'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int LATCH_WIDTH_MS = 2;
	localparam int LATCH_WIDTH_CY = LATCH_WIDTH_MS * 1000 * CLK_MHZ;
	localparam int INIT_MS        = 1500;
	localparam int INIT_CY        = INIT_MS * 1000 * CLK_MHZ;
	localparam int EXT_UNIT_MS    = 100;
	localparam int EXT_UNIT_CY    = EXT_UNIT_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		SSI_MOT_RUN,
		SSI_MOT_DECEL,
		SSI_MOT_LOCK,
		SSI_MOT_HALT
	} ssi_mot_t;

endpackage : ssi_pkg

/* design/ssi_latch_unit.sv */
module ssi_latch_unit
	import ssi_pkg::*;
#(
	parameter int CNT_W  = 32,
	parameter int GAP_CY = 200000
) (
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	// trigger and position
	input  wire logic             trig_in,
	input  wire logic [CNT_W-1:0] pos_in,
	// captured value
	output logic      [CNT_W-1:0] latch_out,
	output logic                  hit_out
);
	localparam int GW = $clog2(GAP_CY + 1);

	logic          prev;
	logic          next_prev;
	logic [GW-1:0] gap;
	logic [GW-1:0] next_gap;
	logic [CNT_W-1:0] next_latch;
	logic          next_hit;

	// rising edge capture, re-armed only after low for the minimum width
	always_comb begin
		next_prev  = trig_in;
		next_latch = latch_out;
		next_hit   = 1'b0;
		next_gap   = gap;
		if (trig_in) begin
			next_gap = '0;
		end else if (gap != GW'(GAP_CY)) begin
			next_gap = gap + 1'b1;
		end
		if (trig_in && !prev && gap == GW'(GAP_CY)) begin
			next_latch = pos_in;
			next_hit   = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prev      <= 1'b1;
			gap       <= '0;
			latch_out <= '0;
			hit_out   <= 1'b0;
		end else begin
			prev      <= next_prev;
			gap       <= next_gap;
			latch_out <= next_latch;
			hit_out   <= next_hit;
		end
	end

	a_latch_edge_capture: assert property (@(posedge core_clk_in) disable iff (rst_in)
		hit_out |-> $past(trig_in) && !$past(prev) && latch_out == $past(pos_in))
		else $error("latch capture without rising edge");

endmodule : ssi_latch_unit

/* design/ssi_seq_input.sv */
module ssi_seq_input
	import ssi_pkg::*;
#(
	parameter int INIT_CYCLES = ssi_pkg::INIT_CY,
	parameter int EXT_CYCLES  = ssi_pkg::EXT_UNIT_CY,
	parameter int LATCH_CYC   = ssi_pkg::LATCH_WIDTH_CY,
	parameter int POS_W       = 32
) (
	// clock and reset
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	// general-purpose inputs, bit 0 is input one
	input  wire logic [ssi_pkg::NUM_IN-1:0] general_input_in,
	input  wire logic [ssi_pkg::NUM_IN*ssi_pkg::SEL_W-1:0] input_sel_in,
	// settings
	input  wire logic [1:0]              prohib_sel_in,
	input  wire logic                    prohib_stop_lock_in,
	input  wire logic [1:0]              fault_reaction_in,
	input  wire logic [1:0]              pole_method_in,
	input  wire logic [7:0]              init_ext_in,
	input  wire logic [2:0]              ctrl_mode_in,
	// motion status
	input  wire logic                    energised_in,
	input  wire logic                    at_search_speed_in,
	input  wire logic                    stopped_in,
	input  wire logic [POS_W-1:0]        feedback_pos_in,
	// power and link status
	input  wire logic                    main_power_in,
	input  wire logic                    other_error_in,
	input  wire logic                    bus_synced_in,
	input  wire logic                    servo_brake_req_in,
	input  wire logic                    bus_brake_req_in,
	input  wire logic                    pole_est_done_in,
	input  wire logic                    pole_est_fail_in,
	// motion commands
	output logic                         cut_output_out,
	output logic [1:0]                   stop_reaction_out,
	output logic                         decel_stop_out,
	output logic                         servo_lock_out,
	output logic                         fwd_allowed_out,
	output logic                         rev_allowed_out,
	output logic                         zero_search_out,
	output logic                         fwd_clamp_out,
	output logic                         rev_clamp_out,
	// status
	output logic                         prohibit_err_out,
	output logic [7:0]                   err_code_out,
	output logic [2:0]                   monitor_out,
	output logic [3*POS_W-1:0]           latch_pos_out,
	output logic [2:0]                   latch_hit_out,
	output logic                         protect_on_out,
	output logic                         ready_out,
	output logic                         brake_release_output,
	output logic                         pole_done_out
);
	localparam int IW = $clog2(longint'(INIT_CYCLES) + longint'(EXT_CYCLES) * 255 + 1);

	// ----------------------------------------
	// synchronise and decode
	// ----------------------------------------
	logic [NUM_IN-1:0] sync1;
	logic [NUM_IN-1:0] sync2;
	logic [NUM_IN-1:0] lvl;
	logic [15:0]       fn_act;
	logic [2:0]        latch_raw;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= general_input_in;
			sync2 <= sync1;
		end
	end

	// over-travel inputs are active when open, so a shorted (high) input allows motion
	always_comb begin
		fn_act    = '0;
		latch_raw = '0;
		lvl       = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			lvl[i] = sync2[i] ^ input_sel_in[i*SEL_W+SEL_INV_BIT];
			fn_act[input_sel_in[i*SEL_W +: 4]] = fn_act[input_sel_in[i*SEL_W +: 4]] | lvl[i];
			if (i >= LATCH_FIRST && i <= LATCH_LAST && !input_sel_in[i*SEL_W+SEL_INV_BIT]) begin
				if (input_sel_in[i*SEL_W +: 4] == FN_LATCH1) latch_raw[0] = sync2[i];
				if (input_sel_in[i*SEL_W +: 4] == FN_LATCH2) latch_raw[1] = sync2[i];
				if (input_sel_in[i*SEL_W +: 4] == FN_LATCH3) latch_raw[2] = sync2[i];
			end
		end
	end

	// ----------------------------------------
	// protection start timer
	// ----------------------------------------
	logic [IW-1:0] init_cnt;
	logic [IW-1:0] next_init_cnt;
	logic [IW-1:0] init_target;
	logic          next_protect;

	always_comb begin
		init_target   = IW'(INIT_CYCLES) + IW'(init_ext_in) * IW'(EXT_CYCLES);
		next_init_cnt = init_cnt;
		next_protect  = protect_on_out;
		if (init_cnt >= init_target) begin
			next_protect = 1'b1;
		end else begin
			next_init_cnt = init_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// stop sequence
	// ----------------------------------------
	ssi_mot_t state;
	ssi_mot_t next_state;
	logic     fwd_block;
	logic     rev_block;
	logic     prohib_en;
	logic     any_block;
	logic     next_err;
	logic     next_cut;
	logic     next_decel;
	logic     next_lock;
	logic [1:0] next_react;

	always_comb begin
		prohib_en  = prohib_sel_in != PROHIB_SEL_STOP;
		fwd_block  = prohib_en && !fn_act[FN_FWD_BLOCK];
		rev_block  = prohib_en && !fn_act[FN_REV_BLOCK];
		any_block  = protect_on_out && (fwd_block || rev_block);
		next_state = state;
		next_err   = prohibit_err_out;
		next_react = fault_reaction_in;
		if (protect_on_out && prohib_sel_in == PROHIB_SEL_ERR && (fwd_block || rev_block)) begin
			next_err = 1'b1;
		end
		unique case (state)
			SSI_MOT_RUN: begin
				if (fn_act[FN_HALT] && energised_in) begin
					next_state = SSI_MOT_HALT;
				end else if (any_block && prohib_sel_in != PROHIB_SEL_ERR) begin
					next_state = SSI_MOT_DECEL;
				end
			end
			SSI_MOT_DECEL: begin
				if (fn_act[FN_HALT] && energised_in) begin
					next_state = SSI_MOT_HALT;
				end else if (stopped_in) begin
					next_state = SSI_MOT_LOCK;
				end
			end
			SSI_MOT_LOCK: begin
				if (fn_act[FN_HALT] && energised_in) begin
					next_state = SSI_MOT_HALT;
				end else if (!any_block) begin
					next_state = SSI_MOT_RUN;
				end
			end
			SSI_MOT_HALT: begin
				if (!fn_act[FN_HALT]) begin
					next_state = SSI_MOT_RUN;
				end
			end
		endcase
		next_cut   = next_state == SSI_MOT_HALT;
		next_decel = next_state == SSI_MOT_DECEL;
		// selection 1 takes lock from the stop selection setting
		next_lock  = next_state == SSI_MOT_LOCK &&
			(prohib_sel_in != PROHIB_SEL_STOP || prohib_stop_lock_in);
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			init_cnt          <= '0;
			protect_on_out    <= 1'b0;
			state             <= SSI_MOT_RUN;
			prohibit_err_out  <= 1'b0;
			err_code_out      <= '0;
			cut_output_out    <= 1'b0;
			stop_reaction_out <= '0;
			decel_stop_out    <= 1'b0;
			servo_lock_out    <= 1'b0;
			fwd_allowed_out   <= 1'b0;
			rev_allowed_out   <= 1'b0;
		end else begin
			init_cnt          <= next_init_cnt;
			protect_on_out    <= next_protect;
			state             <= next_state;
			prohibit_err_out  <= next_err;
			err_code_out      <= next_err ? ERR_PROHIBIT : 8'h00;
			cut_output_out    <= next_cut;
			stop_reaction_out <= next_react;
			decel_stop_out    <= next_decel;
			servo_lock_out    <= next_lock;
			fwd_allowed_out   <= !fwd_block && !next_cut;
			rev_allowed_out   <= !rev_block && !next_cut;
		end
	end

	// ----------------------------------------
	// homing, clamps, monitors, status
	// ----------------------------------------
	logic next_zero;
	logic next_ready;
	logic next_pole;

	always_comb begin
		next_zero  = fn_act[FN_SLOWDOWN] && at_search_speed_in &&
			ctrl_mode_in != MODE_SPEED && ctrl_mode_in != MODE_FORCE;
		next_ready = protect_on_out && main_power_in && !other_error_in &&
			!next_err && bus_synced_in;
		next_pole  = pole_method_in == POLE_METHOD_EST && pole_est_done_in &&
			!pole_est_fail_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			zero_search_out      <= 1'b0;
			fwd_clamp_out        <= 1'b0;
			rev_clamp_out        <= 1'b0;
			monitor_out          <= '0;
			ready_out            <= 1'b0;
			brake_release_output <= 1'b0;
			pole_done_out        <= 1'b0;
		end else begin
			zero_search_out      <= next_zero;
			fwd_clamp_out        <= fn_act[FN_FWD_CLAMP];
			rev_clamp_out        <= fn_act[FN_REV_CLAMP];
			monitor_out          <= {fn_act[FN_MONITOR2], fn_act[FN_MONITOR1],
				fn_act[FN_MONITOR0]};
			ready_out            <= next_ready;
			brake_release_output <= servo_brake_req_in | bus_brake_req_in;
			pole_done_out        <= next_pole;
		end
	end

	// ----------------------------------------
	// position latches
	// ----------------------------------------
	for (genvar k = 0; k < 3; k++) begin : g_latch
		ssi_latch_unit #(
			.CNT_W  (POS_W),
			.GAP_CY (LATCH_CYC)
		) u_latch (
			.core_clk_in (core_clk_in),
			.rst_in      (rst_in),
			.trig_in     (latch_raw[k]),
			.pos_in      (feedback_pos_in),
			.latch_out   (latch_pos_out[k*POS_W +: POS_W]),
			.hit_out     (latch_hit_out[k])
		);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_halt_req;
		fn_act[FN_HALT] && energised_in;
	endsequence
	sequence s_decel_stopped;
		state == SSI_MOT_DECEL && stopped_in && !(fn_act[FN_HALT] && energised_in);
	endsequence
	sequence s_block_enter;
		state == SSI_MOT_RUN && any_block && prohib_sel_in != PROHIB_SEL_ERR &&
			!(fn_act[FN_HALT] && energised_in);
	endsequence

	a_halt_cuts_output: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state == SSI_MOT_RUN ##0 s_halt_req |=> cut_output_out)
		else $error("halt did not cut output");
	a_block_starts_decel: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_block_enter |=> decel_stop_out && !cut_output_out)
		else $error("no deceleration on prohibition");
	a_lock_after_stop: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_decel_stopped |=> state == SSI_MOT_LOCK)
		else $error("no servo lock after stop");
	a_err_code_match: assert property (@(posedge core_clk_in) disable iff (rst_in)
		prohibit_err_out |-> err_code_out == ERR_PROHIBIT)
		else $error("prohibit error without its code");
	a_pole_needs_done: assert property (@(posedge core_clk_in) disable iff (rst_in)
		pole_done_out |-> $past(pole_est_done_in))
		else $error("pole done before estimation finished");
	a_err_only_sel2: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(prohibit_err_out) |-> $past(prohib_sel_in) == PROHIB_SEL_ERR)
		else $error("prohibit error with wrong selection");
	a_no_block_sel1: assert property (@(posedge core_clk_in) disable iff (rst_in)
		prohib_sel_in == PROHIB_SEL_STOP && !fn_act[FN_HALT] ##1 !cut_output_out
		|-> fwd_allowed_out && rev_allowed_out)
		else $error("prohibition active under default");
	a_zero_mode_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
		zero_search_out |-> $past(ctrl_mode_in) != MODE_SPEED && $past(ctrl_mode_in) != MODE_FORCE)
		else $error("slowdown acted in speed or force mode");
	a_ready_needs_all: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ready_out |-> $past(main_power_in) && $past(bus_synced_in) && !$past(other_error_in))
		else $error("ready without conditions");
	a_brake_follows_req: assert property (@(posedge core_clk_in) disable iff (rst_in)
		servo_brake_req_in || bus_brake_req_in |=> brake_release_output)
		else $error("brake release missed");
	a_pole_method_only: assert property (@(posedge core_clk_in) disable iff (rst_in)
		pole_done_out |-> $past(pole_method_in) == POLE_METHOD_EST && !$past(pole_est_fail_in))
		else $error("pole done in wrong method or after fail");
	a_protect_stays: assert property (@(posedge core_clk_in) disable iff (rst_in)
		protect_on_out |=> protect_on_out)
		else $error("protection dropped");

endmodule : ssi_seq_input

/* tb/ssi_host_model.sv */
module ssi_host_model #(
	parameter int WIDTH_CY = 5
) (
	// clock
	input  wire logic       core_clk_in,
	// drive status
	input  wire logic       pole_done_in,
	// latch trigger lines
	output logic      [3:0] trig_out,
	output logic            motion_ok_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// power-up hold-off
	// ----------------------------------------
	int unsigned hold = 0;

	initial trig_out = 4'h0;

	always @(posedge core_clk_in) begin
		if (hold < 64) begin
			hold <= hold + 1;
		end
	end

	// no motion command before pole estimation has finished
	assign motion_ok_out = (hold >= 64) && (pole_done_in === 1'b1);

	// ----------------------------------------
	// trigger pulse with minimum low and high widths
	// ----------------------------------------
	task automatic pulse(input int i);
		repeat (WIDTH_CY + 2) @(posedge core_clk_in);
		trig_out[i] <= 1'b1;
		repeat (WIDTH_CY + 2) @(posedge core_clk_in);
		trig_out[i] <= 1'b0;
		repeat (WIDTH_CY + 2) @(posedge core_clk_in);
	endtask : pulse
endmodule : ssi_host_model

/* tb/servo_sequence_input_handler_test.sv */
module servo_sequence_input_handler_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ssi_pkg::*;

	localparam int INIT_T = 50;
	localparam int EXT_T  = 10;
	localparam int LAT_T  = 5;

	logic        core_clk_in, rst_in;
	logic [3:0]  trig;
	logic [7:0]  gp, iext;
	logic [39:0] sel;
	logic [1:0]  psel, fr, pm;
	logic [2:0]  mode, mon, hit;
	logic        plock, en, srch, stp, mp, oerr, sync, sbr, bbr, pdone, pfail;
	logic [31:0] fpos;
	logic        cut, dstop, lock, fwd, rev, zs, fcl, rcl, perr, pon, rdy, brk, pole;
	logic [1:0]  sreact;
	logic [7:0]  ecode;
	logic [95:0] lpos;
	logic        motion_ok;
	logic [33:0] e;
	logic [33:0] exp_q[$];
	int          bad_count = 0;
	int          num_checks = 0;
	int          hits = 0;

	ssi_seq_input #(.INIT_CYCLES(INIT_T), .EXT_CYCLES(EXT_T), .LATCH_CYC(LAT_T)) dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in),
		.general_input_in({gp[7], trig, gp[2:0]}), .input_sel_in(sel),
		.prohib_sel_in(psel), .prohib_stop_lock_in(plock), .fault_reaction_in(fr),
		.pole_method_in(pm), .init_ext_in(iext), .ctrl_mode_in(mode),
		.energised_in(en), .at_search_speed_in(srch), .stopped_in(stp),
		.feedback_pos_in(fpos), .main_power_in(mp), .other_error_in(oerr),
		.bus_synced_in(sync), .servo_brake_req_in(sbr), .bus_brake_req_in(bbr),
		.pole_est_done_in(pdone), .pole_est_fail_in(pfail),
		.cut_output_out(cut), .stop_reaction_out(sreact), .decel_stop_out(dstop),
		.servo_lock_out(lock), .fwd_allowed_out(fwd), .rev_allowed_out(rev),
		.zero_search_out(zs), .fwd_clamp_out(fcl), .rev_clamp_out(rcl),
		.prohibit_err_out(perr), .err_code_out(ecode), .monitor_out(mon),
		.latch_pos_out(lpos), .latch_hit_out(hit), .protect_on_out(pon),
		.ready_out(rdy), .brake_release_output(brk), .pole_done_out(pole)
	);

	ssi_host_model #(.WIDTH_CY(LAT_T)) host (
		.core_clk_in(core_clk_in), .pole_done_in(pole),
		.trig_out(trig), .motion_ok_out(motion_ok)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick

	task automatic setsel(input int i, input logic [4:0] v);
		@(posedge core_clk_in) sel[5*i +: 5] <= v;
	endtask : setsel

	task automatic do_reset;
		int n;
		n = 0;
		@(posedge core_clk_in) rst_in <= 1'b1;
		tick(5);
		check({cut, pon, rdy, perr, brk}, 0);
		rst_in <= 1'b0;
		while (pon !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		check(n >= INIT_T + 2 * EXT_T - 2 && n <= INIT_T + 2 * EXT_T + 3, 1);
	endtask : do_reset

	// ----------------------------------------
	// latch monitor: each hit takes the oldest note
	// ----------------------------------------
	always @(negedge core_clk_in) begin
		for (int k = 0; k < 3; k++) begin
			if (hit[k] === 1'b1) begin
				hits++;
				if (exp_q.size() == 0) begin
					bad_count++;
					$display("[ERR] %0t capture with no note", $time);
				end else begin
					e = exp_q.pop_front();
					check(k, e[33:32]);
					check(lpos[32*k +: 32], e[31:0]);
				end
			end
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk_in);
		bad_count++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [3:0]  cl[3];
		rst_in = 1'b1;
		gp = 8'h06;
		sel = {5'(FN_MONITOR0), 5'(FN_LATCH1), 5'(FN_LATCH2), 5'(FN_LATCH3),
			5'(FN_NONE), 5'(FN_REV_BLOCK), 5'(FN_FWD_BLOCK), 5'(FN_HALT)};
		{psel, fr, pm, plock, iext, mode} = {2'h0, 2'h0, 2'h0, 1'b0, 8'h02, MODE_POS};
		{en, srch, stp, mp, oerr, sync, sbr, bbr, pdone, pfail} = 10'h050;
		fpos = 32'h0;
		cl = '{4'(FN_MONITOR0), 4'(FN_FWD_CLAMP), 4'(FN_REV_CLAMP)};
		void'($urandom(32'haf7a));
		do_reset();
		tick(5);
		check({rdy, fwd, rev}, 3'h7);
		sync <= 1'b0;
		tick(5);
		check(rdy, 0);
		{sync, mp} <= 2'h2;
		tick(5);
		check(rdy, 0);
		{mp, oerr} <= 2'h3;
		tick(5);
		check(rdy, 0);
		{oerr, psel} <= {1'b0, PROHIB_SEL_STOP};
		gp[1] <= 1'b0;
		tick(5);
		check({fwd, perr}, 2'h2);
		psel <= 2'h0;
		for (int d = 0; d < 2; d++) begin
			gp[1+d] <= 1'b0;
			tick(5);
			check({d ? rev : fwd, dstop}, 2'h1);
			stp <= 1'b1;
			tick(5);
			check({lock, perr}, 2'h2);
			gp[1+d] <= 1'b1;
			stp <= 1'b0;
			do_reset();
		end
		setsel(7, 5'(FN_SLOWDOWN));
		gp[7] <= 1'b1;
		srch <= 1'b1;
		foreach (cl[m]) begin
			mode <= (m == 0) ? MODE_HOMING : (m == 1) ? MODE_SPEED : MODE_FORCE;
			tick(5);
			check(zs, m == 0);
		end
		for (int i = 0; i < 12; i++) begin
			setsel(7, {i[0], 4'(cl[i/4])});
			gp[7] <= i[1] ^ i[0];
			tick(5);
			check(mon, {2'h0, i / 4 == 0 && i[1]});
			check({fcl, rcl}, {i / 4 == 1 && i[1], i / 4 == 2 && i[1]});
			check({fwd, rev}, 2'h3);
		end
		for (int i = 0; i < 4; i++) begin
			{sbr, bbr} <= 2'(i);
			tick(5);
			check(brk, i != 0);
		end
		pdone <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			pm <= 2'(m);
			tick(5);
			check(pole, m == 2);
		end
		{pm, pdone, pfail} <= {POLE_METHOD_EST, 2'h3};
		tick(5);
		check(pole, 0);
		check(motion_ok, 0);
		pdone <= 1'b1;
		pfail <= 1'b0;
		tick(5);
		check(motion_ok, 1);
		for (int b = 3; b > 0; b--) begin
			r = $urandom;
			@(posedge core_clk_in) fpos <= r;
			exp_q.push_back({2'(3 - b), r});
			host.pulse(b);
		end
		setsel(6, {1'b1, FN_LATCH1});
		host.pulse(3);
		setsel(6, 5'(FN_NONE));
		setsel(3, 5'(FN_LATCH1));
		host.pulse(0);
		check(hits, 3);
		setsel(3, 5'(FN_NONE));
		en <= 1'b1;
		fr <= 2'($urandom);
		gp[0] <= 1'b1;
		tick(5);
		check({cut, sreact}, {1'b1, fr});
		gp[0] <= 1'b0;
		en <= 1'b0;
		do_reset();
		psel <= PROHIB_SEL_ERR;
		gp[1] <= 1'b0;
		tick(5);
		check({perr, ecode, rdy}, {1'b1, ERR_PROHIBIT, 1'b0});
		gp[1] <= 1'b1;
		tick(5);
		check(perr, 1);
		complete_run();
	end
endmodule : servo_sequence_input_handler_test
